// [pkg/ppmc_defines.svh]
`ifndef PPMC_DEFINES_SVH
`define PPMC_DEFINES_SVH
// register byte offsets
`define PPMC_CTRL_OFS 4'h0
`define PPMC_RATE_OFS 4'h4
`define PPMC_STAT_OFS 4'h8
`define PPMC_RXST_OFS 4'hC
// control register fields
`define PPMC_CTRL_EN_BIT 0
`define PPMC_CTRL_G12_LSB 1
`define PPMC_CTRL_G3_LSB 3
`define PPMC_CTRL_G4_LSB 5
`define PPMC_CTRL_RST 7'h00
// pll select encodings
`define PPMC_SEL_CHAN 2'h0
`define PPMC_SEL_QUAD0 2'h2
`define PPMC_SEL_QUAD1 2'h3
// rx termination select encodings
`define PPMC_TERM_SUPPLY 2'h0
`define PPMC_TERM_PROG 2'h3
// rx status codes
`define PPMC_RX_OK 3'h0
`define PPMC_RX_SKP_ADD 3'h1
`define PPMC_RX_SKP_DEL 3'h2
`define PPMC_RX_DETECT 3'h3
`define PPMC_RX_DEC_ERR 3'h4
`define PPMC_RX_OVF 3'h5
`define PPMC_RX_UNF 3'h6
`define PPMC_RX_DISP_ERR 3'h7
// timing
`define PPMC_CLK_NS 20
`define PPMC_ALIGN_MIN_CYC 4
`define PPMC_ALIGN_NS 200
`define PPMC_ALIGN_CYC ((`PPMC_ALIGN_NS + `PPMC_CLK_NS - 1) / `PPMC_CLK_NS)
`define PPMC_PLLRST_NS 100
`define PPMC_PLLRST_CYC ((`PPMC_PLLRST_NS + `PPMC_CLK_NS - 1) / `PPMC_CLK_NS)
`define PPMC_LOCK_US 100
`define PPMC_LOCK_CYC ((`PPMC_LOCK_US * 1000) / `PPMC_CLK_NS)
`endif

// [pkg/ppmc_pkg.sv]
package ppmc_pkg;
  // line rate generations
  typedef enum logic [1:0] {GEN1, GEN2, GEN3, GEN4} ppmc_rate_t;
  // pll feeding the channel
  typedef enum logic [1:0] {PLL_CHAN, PLL_QUAD0, PLL_QUAD1} ppmc_pll_t;
  // rate change sequencer
  typedef enum logic [2:0] {
    RC_IDLE, RC_PD, RC_RST, RC_LOCK, RC_DONE
  } ppmc_rc_state_t;
  // reset and alignment sequencer
  typedef enum logic [1:0] {
    RS_RESET, RS_WAIT_REL, RS_ALIGN, RS_RUN
  } ppmc_rs_state_t;
endpackage

// [hdl/ppmc_pipe_ctrl.sv]
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "ppmc_defines.svh"
module ppmc_pipe_ctrl #(
  parameter int LOCK_CYC = `PPMC_LOCK_CYC
) (
  input wire logic clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // async pins from the fabric controller
  input wire logic reset_idle_n,
  input wire logic tx_align_start,
  input wire logic channel_pll_freq_lock,
  input wire logic quad_pll0_freq_lock,
  input wire logic quad_pll1_freq_lock,
  // rx datapath events, same clock
  input wire logic rx_skp_added,
  input wire logic rx_skp_removed,
  input wire logic rx_detected,
  input wire logic rx_decode_err,
  input wire logic rx_ebuf_overflow,
  input wire logic rx_ebuf_underflow,
  input wire logic rx_disparity_err,
  // status outputs
  output logic rate_change_idle,
  output logic tx_align_done,
  output logic gen3_entering,
  output logic gen3_ready,
  output logic shared_pll_powerdown_req,
  output logic shared_pll_reset_req,
  output logic phy_in_reset,
  output logic [2:0] rx_status_code,
  output logic rx_path_gen3,
  output ppmc_pkg::ppmc_pll_t active_pll
);
  import ppmc_pkg::*;

  localparam int ALIGN_CYC = `PPMC_ALIGN_CYC;
  localparam int PLLRST_CYC = `PPMC_PLLRST_CYC;

  // pll chosen for a rate from the select fields
  function automatic ppmc_pll_t pll_for(input ppmc_rate_t r,
                                        input logic [6:0] c);
    logic [1:0] s;
    s = 2'h0;
    pll_for = PLL_CHAN;
    case (r)
      GEN1, GEN2: begin
        s = c[`PPMC_CTRL_G12_LSB +: 2];
        if (s == `PPMC_SEL_QUAD1) pll_for = PLL_QUAD1;
        else if (s == `PPMC_SEL_QUAD0) pll_for = PLL_QUAD0;
        else pll_for = PLL_CHAN;
      end
      GEN3: begin
        s = c[`PPMC_CTRL_G3_LSB +: 2];
        if (s == `PPMC_SEL_QUAD1) pll_for = PLL_QUAD1;
        else pll_for = PLL_QUAD0;
      end
      default: begin
        s = c[`PPMC_CTRL_G4_LSB +: 2];
        if (s == `PPMC_SEL_QUAD0) pll_for = PLL_QUAD0;
        else pll_for = PLL_QUAD1;
      end
    endcase
  endfunction

  // two-flop synchronisers for the async pins
  logic [4:0] meta_r; // first stage, read only by sync_r
  logic [4:0] sync_r; // second stage, safe to use
  logic rst_idle_d_r; // synced reset_idle_n one cycle back
  logic rst_idle_s, align_start_s, chan_lock_s, q0_lock_s, q1_lock_s;

  // control state
  logic [6:0] ctrl_r; // enable and pll select fields
  ppmc_rate_t rate_r; // current line rate
  ppmc_rate_t target_r; // requested line rate
  ppmc_rc_state_t rc_r; // rate change state
  ppmc_rs_state_t rs_r; // reset state
  logic [15:0] rc_cnt_r; // rate change timer
  logic [7:0] al_cnt_r; // alignment timer
  logic [2:0] start_cnt_r; // tx_align_start high count
  logic ack_r; // bus answer phase
  logic start_req; // accepted rate write
  logic pcie_en;
  logic lock_sel;
  ppmc_pll_t target_pll;

  // pin synchroniser chain
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= 5'h01; // reset_idle_n idles high, no false request
      sync_r <= 5'h01;
      rst_idle_d_r <= 1'b1;
    end else begin
      meta_r <= {quad_pll1_freq_lock, quad_pll0_freq_lock,
                 channel_pll_freq_lock, tx_align_start, reset_idle_n};
      sync_r <= meta_r;
      rst_idle_d_r <= sync_r[0];
    end
  end
  assign rst_idle_s = sync_r[0];
  assign align_start_s = sync_r[1];
  assign chan_lock_s = sync_r[2];
  assign q0_lock_s = sync_r[3];
  assign q1_lock_s = sync_r[4];

  assign pcie_en = ctrl_r[`PPMC_CTRL_EN_BIT];
  assign target_pll = pll_for(target_r, ctrl_r);

  // lock of the pll the target rate uses
  always_comb begin
    case (target_pll)
      PLL_QUAD0: lock_sel = q0_lock_s;
      PLL_QUAD1: lock_sel = q1_lock_s;
      default: lock_sel = chan_lock_s;
    endcase
  end

  // bus handshake: one wait cycle per request
  always_ff @(posedge clk) begin
    if (reset) ack_r <= 1'b0;
    else ack_r <= (avs_read | avs_write) & ~ack_r;
  end
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

  // rate write accepted only when idle in pcie mode
  assign start_req = avs_write & ack_r & avs_byteenable[0] &
                     (avs_address == `PPMC_RATE_OFS) & pcie_en &
                     (rc_r == RC_IDLE) & (rs_r == RS_RUN);

  // control register
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= `PPMC_CTRL_RST;
    end else if (avs_write & ack_r & avs_byteenable[0] &
                 (avs_address == `PPMC_CTRL_OFS) & (rc_r == RC_IDLE)) begin
      ctrl_r <= avs_writedata[6:0];
    end
  end

  // read data latched in the wait cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack_r) begin
      case (avs_address)
        `PPMC_CTRL_OFS: avs_readdata <= {25'h0000000, ctrl_r};
        `PPMC_RATE_OFS: avs_readdata <= {28'h0000000, target_r, rate_r};
        `PPMC_STAT_OFS: avs_readdata <= {21'h000000, rc_r, rs_r,
          rx_path_gen3, phy_in_reset, gen3_ready, gen3_entering,
          tx_align_done, rate_change_idle};
        `PPMC_RXST_OFS: avs_readdata <= {29'h00000000, rx_status_code};
        default: avs_readdata <= 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  // rate change sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      rc_r <= RC_IDLE;
      rate_r <= GEN1;
      target_r <= GEN1;
      rc_cnt_r <= 16'h0000;
    end else begin
      case (rc_r)
        RC_IDLE: begin
          rc_cnt_r <= 16'h0000;
          if (start_req) begin
            target_r <= ppmc_rate_t'(avs_writedata[1:0]);
            rc_r <= RC_PD;
          end
        end
        RC_PD: begin
          // quad pll needed: wake it, else straight to lock
          rc_r <= (target_pll == PLL_CHAN) ? RC_LOCK : RC_RST;
        end
        RC_RST: begin
          rc_cnt_r <= rc_cnt_r + 16'h0001;
          if (rc_cnt_r == 16'(PLLRST_CYC - 1)) begin
            rc_cnt_r <= 16'h0000;
            rc_r <= RC_LOCK;
          end
        end
        RC_LOCK: begin
          // lock or timeout ends the wait
          rc_cnt_r <= rc_cnt_r + 16'h0001;
          if (lock_sel || rc_cnt_r == 16'(LOCK_CYC - 1)) rc_r <= RC_DONE;
        end
        RC_DONE: begin
          rate_r <= target_r;
          rc_r <= RC_IDLE;
        end
        default: rc_r <= RC_IDLE;
      endcase
      if (!rst_idle_s) rc_r <= RC_IDLE; // reset aborts a change
    end
  end

  // reset and tx buffer-bypass alignment sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      rs_r <= RS_RESET;
      al_cnt_r <= 8'h00;
      start_cnt_r <= 3'h0;
    end else begin
      case (rs_r)
        RS_RESET: begin
          start_cnt_r <= 3'h0;
          if (rst_idle_s) rs_r <= RS_RUN;
          else rs_r <= RS_WAIT_REL;
        end
        RS_WAIT_REL: begin
          // count start pulse; act when it falls
          if (align_start_s) begin
            if (start_cnt_r != 3'h7) start_cnt_r <= start_cnt_r + 3'h1;
          end else if (start_cnt_r >= 3'(`PPMC_ALIGN_MIN_CYC)) begin
            rs_r <= RS_ALIGN;
            al_cnt_r <= 8'h00;
          end else begin
            start_cnt_r <= 3'h0; // too short, ignored
          end
          if (rst_idle_s && start_cnt_r == 3'h0) rs_r <= RS_RUN;
        end
        RS_ALIGN: begin
          al_cnt_r <= al_cnt_r + 8'h01;
          if (al_cnt_r == 8'(ALIGN_CYC - 1)) rs_r <= RS_RUN;
        end
        RS_RUN: begin
          start_cnt_r <= 3'h0;
          if (!rst_idle_s && !tx_align_done) rs_r <= RS_WAIT_REL;
        end
        default: rs_r <= RS_RESET;
      endcase
    end
  end

  // done flag: set at end of alignment, cleared by reset request
  always_ff @(posedge clk) begin
    if (reset) tx_align_done <= 1'b0;
    else if (rs_r == RS_ALIGN && al_cnt_r == 8'(ALIGN_CYC - 1))
      tx_align_done <= 1'b1;
    else if (rst_idle_d_r && !rst_idle_s) tx_align_done <= 1'b0;
  end

  // status outputs from state
  always_ff @(posedge clk) begin
    if (reset) begin
      rate_change_idle <= 1'b1;
      gen3_entering <= 1'b0;
      gen3_ready <= 1'b0;
      shared_pll_powerdown_req <= 1'b1;
      shared_pll_reset_req <= 1'b0;
      phy_in_reset <= 1'b1;
      rx_path_gen3 <= 1'b0;
      active_pll <= PLL_CHAN;
    end else begin
      rate_change_idle <= (rc_r == RC_IDLE) & ~start_req;
      gen3_entering <= (rc_r != RC_IDLE) & (target_r == GEN3);
      gen3_ready <= pcie_en & (rc_r == RC_IDLE) &
                    (rate_r == GEN3) & (rs_r == RS_RUN);
      // quad pll unused: keep it powered down
      shared_pll_powerdown_req <= ~pcie_en |
        ((rc_r == RC_IDLE) & (pll_for(rate_r, ctrl_r) == PLL_CHAN)) |
        ((rc_r != RC_IDLE) & (target_pll == PLL_CHAN));
      shared_pll_reset_req <= (rc_r == RC_RST);
      phy_in_reset <= (rs_r != RS_RUN);
      rx_path_gen3 <= pcie_en & (rate_r != GEN1) & (rate_r != GEN2);
      active_pll <= pll_for(rate_r, ctrl_r);
    end
  end

  // rx status encoder, errors win over info
  always_ff @(posedge clk) begin
    if (reset) rx_status_code <= `PPMC_RX_OK;
    else if (!pcie_en || rx_path_gen3) rx_status_code <= `PPMC_RX_OK;
    else if (rx_decode_err) rx_status_code <= `PPMC_RX_DEC_ERR;
    else if (rx_disparity_err) rx_status_code <= `PPMC_RX_DISP_ERR;
    else if (rx_ebuf_overflow) rx_status_code <= `PPMC_RX_OVF;
    else if (rx_ebuf_underflow) rx_status_code <= `PPMC_RX_UNF;
    else if (rx_detected) rx_status_code <= `PPMC_RX_DETECT;
    else if (rx_skp_removed) rx_status_code <= `PPMC_RX_SKP_DEL;
    else if (rx_skp_added) rx_status_code <= `PPMC_RX_SKP_ADD;
    else rx_status_code <= `PPMC_RX_OK;
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_busy_idle_low:
    assert property ((rc_r != RC_IDLE) |=> !rate_change_idle)
      else $error("rate_change_idle high during change");
  a_idle_returns:
    assert property ((rc_r == RC_IDLE) && !start_req |=> rate_change_idle)
      else $error("rate_change_idle low while idle");
  a_align_done_time:
    assert property ($rose(tx_align_done) |->
      $past(rs_r) == RS_ALIGN && rs_r == RS_RUN)
      else $error("tx_align_done rose outside alignment");
  a_gen3_enter:
    assert property (start_req && avs_writedata[1:0] == 2'h2 |=>
      ##1 gen3_entering)
      else $error("gen3_entering missing on gen3 change");
  a_gen3_ready_rate:
    assert property (gen3_ready |-> $past(rate_r) == GEN3)
      else $error("gen3_ready without gen3 rate");
  a_pll_reset_len:
    assert property ($rose(shared_pll_reset_req) |->
      shared_pll_reset_req [*5] ##1 !shared_pll_reset_req)
      else $error("shared pll reset pulse length wrong");
  a_pd_off_quad:
    assert property (shared_pll_reset_req |-> !shared_pll_powerdown_req)
      else $error("quad pll reset while powered down");
  a_phy_rst_follow:
    assert property ((rs_r != RS_RUN) |=> phy_in_reset)
      else $error("phy_in_reset low while in reset");
  a_rx_dec_err:
    assert property (pcie_en && !rx_path_gen3 && rx_decode_err |=>
      rx_status_code == `PPMC_RX_DEC_ERR)
      else $error("decode error not reported");
  a_rx_skp_add:
    assert property (pcie_en && !rx_path_gen3 && rx_skp_added &&
      !rx_decode_err && !rx_disparity_err && !rx_ebuf_overflow &&
      !rx_ebuf_underflow && !rx_detected && !rx_skp_removed |=>
      rx_status_code == `PPMC_RX_SKP_ADD)
      else $error("skp added not reported");
  a_wait_one:
    assert property (avs_read && !ack_r |=> !avs_waitrequest)
      else $error("read not answered after one wait cycle");
  a_gen12_quad1:
    assert property ((rate_r == GEN1 || rate_r == GEN2) && pcie_en &&
      rc_r == RC_IDLE && ctrl_r[2:1] == 2'h3 |=> active_pll == PLL_QUAD1)
      else $error("gen12 select 11 not quad pll1");

  c_rate_change: cover property (start_req ##[1:20] rate_change_idle);
  c_gen3_reached: cover property ($rose(gen3_ready));
  c_align_done: cover property ($rose(tx_align_done));
  c_rx_error: cover property (rx_status_code == `PPMC_RX_OVF);
endmodule

// [testbench/ppmc_fabric_model.sv]
`timescale 1ns/1ps
`include "ppmc_defines.svh"
// fabric controller: pll lock wiring and pcie reset requests
module ppmc_fabric_model (
  input wire logic clk,
  input wire logic shared_pll_powerdown_req,
  input wire logic shared_pll_reset_req,
  output logic reset_idle_n,
  output logic tx_align_start,
  output logic channel_pll_freq_lock,
  output logic quad_pll0_freq_lock,
  output logic quad_pll1_freq_lock
);
  logic [1:0] qcnt = 2'h0; // shared pll settle count
  // termination mode written over the reconfig port, programmable at rest
  logic [1:0] rx_termination_select = `PPMC_TERM_PROG;
  // channel pll runs free, both quad locks follow the shared pll
  assign channel_pll_freq_lock = 1'b1;
  assign quad_pll0_freq_lock = &qcnt;
  assign quad_pll1_freq_lock = &qcnt;
  // lock is lost while the shared pll is off or in reset
  always @(posedge clk) begin
    if (shared_pll_powerdown_req || shared_pll_reset_req) begin
      qcnt <= 2'h0;
    end else if (!(&qcnt)) begin
      qcnt <= qcnt + 2'h1;
    end
  end
  // idle: no reset request, no alignment start
  initial begin
    reset_idle_n = 1'b1;
    tx_align_start = 1'b0;
  end
  // request a reset, then hold start for len cycles
  task start_reset(input int len);
    @(posedge clk) reset_idle_n <= 1'b0;
    repeat (4) @(posedge clk);
    tx_align_start <= 1'b1;
    repeat (len) @(posedge clk);
    tx_align_start <= 1'b0;
  endtask
  // receiver detection: falling-edge remote needs supply termination
  task rx_detect(input logic falling, input int len);
    if (falling) begin
      @(posedge clk) rx_termination_select <= `PPMC_TERM_SUPPLY;
      repeat (len) @(posedge clk);
      rx_termination_select <= `PPMC_TERM_PROG;
    end else begin
      repeat (len) @(posedge clk);
    end
    @(negedge clk);
  endtask
  // report the reset as complete
  task end_reset();
    @(posedge clk) reset_idle_n <= 1'b1;
  endtask
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
`include "ppmc_defines.svh"
// compare, count and report one value
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  fails++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module testbench;
  import ppmc_pkg::*;
  // one rate change case: control word, target, expected pll
  typedef struct packed {
    logic [6:0] ctrl;
    logic [1:0] rate;
    ppmc_pll_t pll;
  } ppmc_tb_row_t;
  localparam int LOCK = 20; // shortened lock wait
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, reset_idle_n, tx_align_start;
  logic ch_lock, q0_lock, q1_lock, rate_change_idle, tx_align_done;
  logic gen3_entering, gen3_ready, pll_pd, pll_rst, phy_in_reset;
  logic rx_path_gen3, ent;
  logic [2:0] rx_status_code;
  ppmc_pll_t active_pll;
  logic [6:0] rx_ev = 7'h00; // disp unf ovf dec det rm add
  int fails = 0;
  int num_checks = 0;
  int lows, rsts, n;
  // event inputs beside the code they give
  logic [9:0] rx_rows [13] = '{{7'h00, `PPMC_RX_OK},
    {7'h01, `PPMC_RX_SKP_ADD}, {7'h02, `PPMC_RX_SKP_DEL},
    {7'h04, `PPMC_RX_DETECT}, {7'h08, `PPMC_RX_DEC_ERR},
    {7'h10, `PPMC_RX_OVF}, {7'h20, `PPMC_RX_UNF},
    {7'h40, `PPMC_RX_DISP_ERR}, {7'h48, `PPMC_RX_DEC_ERR},
    {7'h7F, `PPMC_RX_DEC_ERR}, {7'h30, `PPMC_RX_OVF},
    {7'h06, `PPMC_RX_DETECT}, {7'h03, `PPMC_RX_SKP_DEL}};
  // gen3 on quad1, gen4 on quad0, gen1 channel, gen2 quad1, then the
  // codes: gen2 10 quad0, fallbacks gen3 00 quad0, gen4 00 quad1
  ppmc_tb_row_t rc_rows [7] = '{'{7'h59, 2'h2, PLL_QUAD1},
    '{7'h59, 2'h3, PLL_QUAD0}, '{7'h59, 2'h0, PLL_CHAN},
    '{7'h5F, 2'h1, PLL_QUAD1}, '{7'h05, 2'h1, PLL_QUAD0},
    '{7'h05, 2'h2, PLL_QUAD0}, '{7'h05, 2'h3, PLL_QUAD1}};
  always #10 clk = ~clk;
  ppmc_pipe_ctrl #(.LOCK_CYC(LOCK)) i_dut (.clk(clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .reset_idle_n(reset_idle_n),
    .tx_align_start(tx_align_start), .channel_pll_freq_lock(ch_lock),
    .quad_pll0_freq_lock(q0_lock), .quad_pll1_freq_lock(q1_lock),
    .rx_skp_added(rx_ev[0]), .rx_skp_removed(rx_ev[1]),
    .rx_detected(rx_ev[2]), .rx_decode_err(rx_ev[3]),
    .rx_ebuf_overflow(rx_ev[4]), .rx_ebuf_underflow(rx_ev[5]),
    .rx_disparity_err(rx_ev[6]), .rate_change_idle(rate_change_idle),
    .tx_align_done(tx_align_done), .gen3_entering(gen3_entering),
    .gen3_ready(gen3_ready), .shared_pll_powerdown_req(pll_pd),
    .shared_pll_reset_req(pll_rst), .phy_in_reset(phy_in_reset),
    .rx_status_code(rx_status_code), .rx_path_gen3(rx_path_gen3),
    .active_pll(active_pll));
  ppmc_fabric_model i_model (.clk(clk), .shared_pll_powerdown_req(pll_pd),
    .shared_pll_reset_req(pll_rst), .reset_idle_n(reset_idle_n),
    .tx_align_start(tx_align_start), .channel_pll_freq_lock(ch_lock),
    .quad_pll0_freq_lock(q0_lock), .quad_pll1_freq_lock(q1_lock));
  // counts, verdict, end of run
  task close_out();
    $display("checks %0d errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one avalon cycle, held until waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      close_out();
    end
  endtask
  // present events for one cycle, look at the code after
  task rx_try(input logic [6:0] ev);
    @(posedge clk) rx_ev <= ev;
    @(posedge clk) rx_ev <= 7'h00;
    @(negedge clk);
  endtask
  // request a rate and watch busy, pll reset and gen3 entry
  task rate_change(input logic [1:0] r);
    bus(1'b1, `PPMC_RATE_OFS, {30'h0, r});
    lows = 0;
    rsts = 0;
    ent = 1'b0;
    for (int i = 0; i < 300; i++) begin
      @(negedge clk);
      if (rate_change_idle === 1'b0) lows++;
      if (pll_rst === 1'b1) rsts++;
      if (gen3_entering === 1'b1) ent = 1'b1;
      // refused: idle never drops; started and never back: timeout
      if (rate_change_idle === 1'b1 && (lows > 0 || i == 4)) break;
      if (i == 299) begin
        fails++;
        close_out();
      end
    end
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    `CHK("idle", 1'b1, rate_change_idle)
    `CHK("align", 1'b0, tx_align_done)
    `CHK("g3 in", 1'b0, gen3_entering)
    `CHK("g3 rdy", 1'b0, gen3_ready)
    `CHK("pd", 1'b1, pll_pd)
    `CHK("prst", 1'b0, pll_rst)
    `CHK("phyrst", 1'b1, phy_in_reset)
    `CHK("rxst", `PPMC_RX_OK, rx_status_code)
    reset <= 1'b0;
    bus(1'b0, `PPMC_CTRL_OFS, 32'h0);
    `CHK("ctrl", {25'h0, `PPMC_CTRL_RST}, rd)
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    bus(1'b0, 4'h2, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    avs_byteenable <= 4'h0;
    bus(1'b1, `PPMC_CTRL_OFS, 32'h59);
    avs_byteenable <= 4'hF;
    bus(1'b0, `PPMC_CTRL_OFS, 32'h0);
    `CHK("no lanes", 32'h0, rd)
    rate_change(2'h2);
    `CHK("off busy", 0, lows)
    rx_try(7'h08);
    `CHK("off rxst", `PPMC_RX_OK, rx_status_code)
    bus(1'b1, `PPMC_CTRL_OFS, 32'h59);
    foreach (rx_rows[k]) begin
      rx_try(rx_rows[k][9:3]);
      `CHK("rxst", rx_rows[k][2:0], rx_status_code)
    end
    `CHK("phyrst", 1'b0, phy_in_reset)
    i_model.rx_detect(1'b1, 3);
    `CHK("term", `PPMC_TERM_PROG, i_model.rx_termination_select)
    rx_try(7'h04);
    `CHK("rxst", `PPMC_RX_DETECT, rx_status_code)
    i_model.rx_detect(1'b0, 3);
    `CHK("term", `PPMC_TERM_PROG, i_model.rx_termination_select)
    i_model.start_reset(2);
    repeat (20) @(negedge clk);
    `CHK("phyrst", 1'b1, phy_in_reset)
    `CHK("short", 1'b0, tx_align_done)
    i_model.start_reset(8);
    for (int i = 0; i < 60 && tx_align_done !== 1'b1; i++) @(negedge clk);
    `CHK("align", 1'b1, tx_align_done)
    i_model.end_reset();
    repeat (10) @(negedge clk);
    `CHK("phyrst", 1'b0, phy_in_reset)
    `CHK("align", 1'b1, tx_align_done)
    foreach (rc_rows[k]) begin
      bus(1'b1, `PPMC_CTRL_OFS, {25'h0, rc_rows[k].ctrl});
      rate_change(rc_rows[k].rate);
      `CHK("busy", 1'b1, lows > 0)
      `CHK("idle", 1'b1, rate_change_idle)
      `CHK("prst", (rc_rows[k].pll == PLL_CHAN) ? 0 : `PPMC_PLLRST_CYC,
        rsts)
      `CHK("pd", rc_rows[k].pll == PLL_CHAN, pll_pd)
      `CHK("g3 in", rc_rows[k].rate == 2'h2, ent)
      `CHK("g3 rdy", rc_rows[k].rate == 2'h2, gen3_ready)
      `CHK("pll", rc_rows[k].pll, active_pll)
      `CHK("path", rc_rows[k].rate[1], rx_path_gen3)
      rx_try(7'h08);
      `CHK("rxst", rc_rows[k].rate[1] ? `PPMC_RX_OK : `PPMC_RX_DEC_ERR,
        rx_status_code)
      bus(1'b0, `PPMC_RATE_OFS, 32'h0);
      `CHK("rate", rc_rows[k].rate, rd[1:0])
    end
    close_out();
  end
endmodule
